// ===== sbt_tap.sv
// boundary-scan test access port of a synchronous memory
// assumes tms/tdi come from pads with pull-ups and are synchronous to tck_i;
// the memory side runs on clk_i, unrelated to tck_i
//
// Summary of operation
// - sample inputs on rise, drive output on fall
// - mode-select sampled each rise, pulled high
// - serial input pulled high when unconnected
// - shift in at MSB, out at LSB
// - serial output driven only while shifting
// - five high mode-select edges reset test logic
// - power-up reset leaves serial output high-Z
// - instruction selects exactly one scan register
// - three-bit instruction register shifted serially
// - reset presets instruction to identification read
// - instruction capture loads low bits 01
// - one-bit bypass register, cleared at capture
// - one boundary cell per input ball
// - data capture loads ring, then shifts
// - three test instructions capture the ring
// - identification capture loads fixed 32-bit code
// - all-zero instruction samples and disables outputs
// - sample-z disables outputs, selects boundary register
// - new instruction acts only at update
`timescale 1ns/1ps

module sbt_tap #(
	parameter int unsigned BSR_W = 40
) (
	input  wire logic                 clk_i,
	input  wire logic                 sys_rst_i,
	input  wire logic                 tck_i,
	input  wire sbt_pkg::sbt_tap_in_s tap_i,
	input  wire logic [BSR_W-1:0]     ring_i,
	output logic                      tdo_o,
	output logic                      tdo_oe_n_o,
	output logic                      mem_out_disable_o
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic sbt_pkg::sbt_dr_e dr_select(input logic [sbt_pkg::IR_W-1:0] op);
		unique case (op)
			sbt_pkg::OP_EXT_TEST,
			sbt_pkg::OP_SAMPLE_Z,
			sbt_pkg::OP_SAMPLE:   dr_select = sbt_pkg::DR_BOUNDARY;
			sbt_pkg::OP_IDCODE:   dr_select = sbt_pkg::DR_ID;
			default:              dr_select = sbt_pkg::DR_BYPASS;
		endcase
	endfunction

	function automatic logic outs_off(input logic [sbt_pkg::IR_W-1:0] op);
		outs_off = (op == sbt_pkg::OP_EXT_TEST) || (op == sbt_pkg::OP_SAMPLE_Z);
	endfunction

	// ------------------------------------------------------------
	// resets and controller
	// ------------------------------------------------------------
	logic                rst_tck;
	sbt_pkg::sbt_state_e state;

	// power-up reset reaches the test clock domain through two flops
	sbt_sync #(
		.WIDTH   (1),
		.RST_VAL (1'b1)
	) u_rst_sync (
		.clk_i (tck_i),
		.rst_i (1'b0),
		.d_i   (sys_rst_i),
		.q_o   (rst_tck)
	);

	// mode-select arrives already high when the pad is left open
	sbt_tap_fsm u_fsm (
		.tck_i   (tck_i),
		.rst_i   (rst_tck),
		.tms_i   (tap_i.tms),
		.state_o (state)
	);

	logic tlr;
	logic cap_dr;
	logic sh_dr;
	logic cap_ir;
	logic sh_ir;
	logic up_ir;

	assign tlr    = (state == sbt_pkg::ST_RESET);
	assign cap_dr = (state == sbt_pkg::ST_CAP_DR);
	assign sh_dr  = (state == sbt_pkg::ST_SH_DR);
	assign cap_ir = (state == sbt_pkg::ST_CAP_IR);
	assign sh_ir  = (state == sbt_pkg::ST_SH_IR);
	assign up_ir  = (state == sbt_pkg::ST_UP_IR);

	// ------------------------------------------------------------
	// instruction register
	// ------------------------------------------------------------
	logic [sbt_pkg::IR_W-1:0] ir_reg;
	logic [sbt_pkg::IR_W-1:0] ir_sh_reg;
	sbt_pkg::sbt_dr_e         dr_sel;

	assign dr_sel = dr_select(ir_reg);

	always_ff @(posedge tck_i)
	begin
		if (rst_tck)
			ir_sh_reg <= sbt_pkg::OP_IDCODE;
		else if (cap_ir)
			ir_sh_reg <= {sbt_pkg::IR_CAPT_TOP, sbt_pkg::IR_CAPT_LOW};
		else if (sh_ir)
			ir_sh_reg <= {tap_i.tdi, ir_sh_reg[sbt_pkg::IR_W-1:1]};
	end

	// active instruction changes only at update or reset
	always_ff @(posedge tck_i)
	begin
		if (rst_tck || tlr)
			ir_reg <= sbt_pkg::OP_IDCODE;
		else if (up_ir)
			ir_reg <= ir_sh_reg;
	end

	// ------------------------------------------------------------
	// ring crossing: clk_i snapshot handed over by toggle handshake
	// ------------------------------------------------------------
	logic [BSR_W-1:0] ring_meta_reg;
	logic [BSR_W-1:0] ring_sync_reg;
	logic [BSR_W-1:0] ring_hold_reg;
	logic             req_reg;
	logic             ack_clk;
	logic             req_tck;
	logic             ack_reg;
	logic [BSR_W-1:0] ring_tck_reg;

	// ring pins are asynchronous to clk_i
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			ring_meta_reg <= '0;
			ring_sync_reg <= '0;
		end
		else
		begin
			ring_meta_reg <= ring_i;
			ring_sync_reg <= ring_meta_reg;
		end
	end

	// hold stays put until the test side acknowledges
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			ring_hold_reg <= '0;
			req_reg       <= 1'b0;
		end
		else if (req_reg == ack_clk)
		begin
			ring_hold_reg <= ring_sync_reg;
			req_reg       <= ~req_reg;
		end
	end

	sbt_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_req_sync (
		.clk_i (tck_i),
		.rst_i (rst_tck),
		.d_i   (req_reg),
		.q_o   (req_tck)
	);

	sbt_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_ack_sync (
		.clk_i (clk_i),
		.rst_i (sys_rst_i),
		.d_i   (ack_reg),
		.q_o   (ack_clk)
	);

	// the copy is at most a few test clocks old; a ring that moves is not exact
	always_ff @(posedge tck_i)
	begin
		if (rst_tck)
		begin
			ring_tck_reg <= '0;
			ack_reg      <= 1'b0;
		end
		else if (req_tck != ack_reg)
		begin
			ring_tck_reg <= ring_hold_reg;
			ack_reg      <= req_tck;
		end
	end

	// ------------------------------------------------------------
	// data registers
	// ------------------------------------------------------------
	logic                     byp_reg;
	logic [sbt_pkg::ID_W-1:0] id_reg;
	logic [BSR_W-1:0]         bsr_reg;

	always_ff @(posedge tck_i)
	begin
		if (rst_tck)
			byp_reg <= sbt_pkg::BYP_CAPT;
		else if (cap_dr && dr_sel == sbt_pkg::DR_BYPASS)
			byp_reg <= sbt_pkg::BYP_CAPT;
		else if (sh_dr && dr_sel == sbt_pkg::DR_BYPASS)
			byp_reg <= tap_i.tdi;
	end

	always_ff @(posedge tck_i)
	begin
		if (rst_tck)
			id_reg <= sbt_pkg::ID_VALUE;
		else if (cap_dr && dr_sel == sbt_pkg::DR_ID)
			id_reg <= sbt_pkg::ID_VALUE;
		else if (sh_dr && dr_sel == sbt_pkg::DR_ID)
			id_reg <= {tap_i.tdi, id_reg[sbt_pkg::ID_W-1:1]};
	end

	// one cell per ball; shifted-in data has no parallel output
	always_ff @(posedge tck_i)
	begin
		if (rst_tck)
			bsr_reg <= '0;
		else if (cap_dr && dr_sel == sbt_pkg::DR_BOUNDARY)
			bsr_reg <= ring_tck_reg;
		else if (sh_dr && dr_sel == sbt_pkg::DR_BOUNDARY)
			bsr_reg <= {tap_i.tdi, bsr_reg[BSR_W-1:1]};
	end

	// ------------------------------------------------------------
	// serial output on the falling edge
	// ------------------------------------------------------------
	logic tdo_bit;
	logic tdo_reg;
	logic tdo_oe_n_reg;

	always_comb
	begin
		tdo_bit = byp_reg;
		if (sh_ir)
			tdo_bit = ir_sh_reg[0];
		else
			unique case (dr_sel)
				sbt_pkg::DR_ID:       tdo_bit = id_reg[0];
				sbt_pkg::DR_BOUNDARY: tdo_bit = bsr_reg[0];
				default:              tdo_bit = byp_reg;
			endcase
	end

	always_ff @(negedge tck_i)
	begin
		if (rst_tck)
		begin
			tdo_reg      <= 1'b0;
			tdo_oe_n_reg <= 1'b1;
		end
		else
		begin
			tdo_reg      <= tdo_bit;
			tdo_oe_n_reg <= ~(sh_ir || sh_dr);
		end
	end

	assign tdo_o      = tdo_reg;
	assign tdo_oe_n_o = tdo_oe_n_reg;

	// ------------------------------------------------------------
	// output disable into the memory domain
	// ------------------------------------------------------------
	logic off_tck_reg;

	always_ff @(posedge tck_i)
	begin
		if (rst_tck || tlr)
			off_tck_reg <= 1'b0;
		else if (up_ir)
			off_tck_reg <= outs_off(ir_sh_reg);
	end

	// test reset never touches memory state, only this level
	sbt_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_off_sync (
		.clk_i (clk_i),
		.rst_i (sys_rst_i),
		.d_i   (off_tck_reg),
		.q_o   (mem_out_disable_o)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_tms_five_reset: assert property (@(posedge tck_i) disable iff (rst_tck)
		tap_i.tms [*5] |=> tlr)
		else $error("five high tms did not reach reset");
	chk_ir_preset: assert property (@(posedge tck_i) disable iff (rst_tck)
		tlr |=> ir_reg == sbt_pkg::OP_IDCODE)
		else $error("instruction not preset to idcode");
	chk_ir_capture: assert property (@(posedge tck_i) disable iff (rst_tck)
		cap_ir |=> ir_sh_reg[1:0] == sbt_pkg::IR_CAPT_LOW)
		else $error("instruction capture pattern wrong");
	chk_ir_update_only: assert property (@(posedge tck_i) disable iff (rst_tck)
		!up_ir && !tlr |=> $stable(ir_reg))
		else $error("instruction changed outside update");
	chk_ir_shift_in: assert property (@(posedge tck_i) disable iff (rst_tck)
		sh_ir |=> ir_sh_reg[sbt_pkg::IR_W-1] == $past(tap_i.tdi))
		else $error("instruction shift did not enter at msb");
	chk_id_capture: assert property (@(posedge tck_i) disable iff (rst_tck)
		cap_dr && dr_sel == sbt_pkg::DR_ID |=> id_reg == sbt_pkg::ID_VALUE)
		else $error("id capture wrong");
	chk_bypass_clear: assert property (@(posedge tck_i) disable iff (rst_tck)
		cap_dr && dr_sel == sbt_pkg::DR_BYPASS |=> byp_reg == 1'b0)
		else $error("bypass not cleared on capture");
	chk_bsr_capture: assert property (@(posedge tck_i) disable iff (rst_tck)
		cap_dr && dr_sel == sbt_pkg::DR_BOUNDARY |=> bsr_reg == $past(ring_tck_reg))
		else $error("boundary capture wrong");
	chk_tdo_hiz_idle: assert property (@(negedge tck_i) disable iff (rst_tck)
		!sh_ir && !sh_dr |=> tdo_oe_n_o)
		else $error("tdo driven outside shift");
	chk_tdo_lsb: assert property (@(negedge tck_i) disable iff (rst_tck)
		sh_dr && dr_sel == sbt_pkg::DR_ID |=> !tdo_oe_n_o && tdo_o == $past(id_reg[0]))
		else $error("tdo not from id lsb");
	chk_reserved_bypass: assert property (@(posedge tck_i) disable iff (rst_tck)
		ir_reg == 3'h3 |-> dr_sel == sbt_pkg::DR_BYPASS)
		else $error("reserved opcode not on bypass");
	chk_outs_off: assert property (@(posedge tck_i) disable iff (rst_tck)
		ir_reg == sbt_pkg::OP_SAMPLE_Z && $stable(ir_reg) |=> off_tck_reg)
		else $error("sample-z did not disable outputs");

	cov_id_shift:  cover property (@(posedge tck_i) cap_dr && dr_sel == sbt_pkg::DR_ID ##1 sh_dr);
	cov_ir_update: cover property (@(posedge tck_i) up_ir ##1 ir_reg == sbt_pkg::OP_EXT_TEST);
	cov_bsr_shift: cover property (@(posedge tck_i)
		cap_dr && dr_sel == sbt_pkg::DR_BOUNDARY ##1 sh_dr [*3]);
	cov_tms_reset: cover property (@(posedge tck_i) !tlr ##1 tap_i.tms [*5]);

endmodule

// ===== sbt_pkg.sv
// package of the boundary-scan test port: states, opcodes, widths, carriers
// assumes nothing; every file names its items as sbt_pkg::name
package sbt_pkg;

	// ------------------------------------------------------------
	// widths and fixed patterns
	// ------------------------------------------------------------
	localparam int unsigned IR_W        = 3;
	localparam int unsigned ID_W        = 32;
	localparam int unsigned TLR_TMS_CNT = 5;
	localparam logic [1:0]  IR_CAPT_LOW = 2'b01;
	localparam logic        IR_CAPT_TOP = 1'b0;
	localparam logic        BYP_CAPT    = 1'b0;

	// ------------------------------------------------------------
	// opcodes; all but the all-zero one are free choices
	// ------------------------------------------------------------
	localparam logic [IR_W-1:0] OP_EXT_TEST = 3'h0;
	localparam logic [IR_W-1:0] OP_IDCODE   = 3'h1;
	localparam logic [IR_W-1:0] OP_SAMPLE_Z = 3'h2;
	localparam logic [IR_W-1:0] OP_SAMPLE   = 3'h4;
	localparam logic [IR_W-1:0] OP_BYPASS   = 3'h7;

	// arbitrary identification value, names no maker
	localparam logic [ID_W-1:0] ID_VALUE    = 32'h1234_5679;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE,
		ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UP_DR,
		ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UP_IR
	} sbt_state_e;

	typedef enum logic [1:0] {
		DR_BYPASS, DR_ID, DR_BOUNDARY
	} sbt_dr_e;

	typedef struct packed {
		logic tms;
		logic tdi;
	} sbt_tap_in_s;

endpackage

// ===== sbt_sync.sv
// two-flop level synchroniser, reset synchronously in the destination domain
// assumes the source is a level that holds for several destination clocks
`timescale 1ns/1ps

module sbt_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] q_reg;

	// first stage feeds only the second stage
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_reg <= RST_VAL;
			q_reg    <= RST_VAL;
		end
		else
		begin
			meta_reg <= d_i;
			q_reg    <= meta_reg;
		end
	end

	assign q_o = q_reg;

endmodule

// ===== sbt_tap_fsm.sv
// sixteen-state test port controller, stepped by mode-select on test clock rise
// assumes mode-select is synchronous to the test clock
`timescale 1ns/1ps

module sbt_tap_fsm (
	input  wire logic                tck_i,
	input  wire logic                rst_i,
	input  wire logic                tms_i,
	output sbt_pkg::sbt_state_e      state_o
);

	sbt_pkg::sbt_state_e state_reg;
	sbt_pkg::sbt_state_e state_next;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			sbt_pkg::ST_RESET:  state_next = tms_i ? sbt_pkg::ST_RESET  : sbt_pkg::ST_IDLE;
			sbt_pkg::ST_IDLE:   state_next = tms_i ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
			sbt_pkg::ST_SEL_DR: state_next = tms_i ? sbt_pkg::ST_SEL_IR : sbt_pkg::ST_CAP_DR;
			sbt_pkg::ST_CAP_DR: state_next = tms_i ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_SH_DR:  state_next = tms_i ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_EX1_DR: state_next = tms_i ? sbt_pkg::ST_UP_DR  : sbt_pkg::ST_PA_DR;
			sbt_pkg::ST_PA_DR:  state_next = tms_i ? sbt_pkg::ST_EX2_DR : sbt_pkg::ST_PA_DR;
			sbt_pkg::ST_EX2_DR: state_next = tms_i ? sbt_pkg::ST_UP_DR  : sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_UP_DR:  state_next = tms_i ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
			sbt_pkg::ST_SEL_IR: state_next = tms_i ? sbt_pkg::ST_RESET  : sbt_pkg::ST_CAP_IR;
			sbt_pkg::ST_CAP_IR: state_next = tms_i ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_SH_IR:  state_next = tms_i ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_EX1_IR: state_next = tms_i ? sbt_pkg::ST_UP_IR  : sbt_pkg::ST_PA_IR;
			sbt_pkg::ST_PA_IR:  state_next = tms_i ? sbt_pkg::ST_EX2_IR : sbt_pkg::ST_PA_IR;
			sbt_pkg::ST_EX2_IR: state_next = tms_i ? sbt_pkg::ST_UP_IR  : sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_UP_IR:  state_next = tms_i ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
		endcase
	end

	// five high mode-select samples reach reset from any state
	always_ff @(posedge tck_i)
	begin
		if (rst_i)
			state_reg <= sbt_pkg::ST_RESET;
		else
			state_reg <= state_next;
	end

	assign state_o = state_reg;

endmodule

// ===== sbt_jtag_model.sv
// model of the external test controller that drives the serial test port
// assumes the port samples on tck rise and drives tdo on the following fall
`timescale 1ns/1ps

module sbt_jtag_model (
	output logic                tck_o,
	output sbt_pkg::sbt_tap_in_s tap_o,
	input  wire logic           tdo_i,
	input  wire logic           tdo_oe_n_i
);
	logic last;

	// ------------------------------------------------------------
	// idle levels
	// ------------------------------------------------------------
	// clock rests low between frames, so the port sees no edge
	// both inputs start at their pull-up level; tms is left low after each scan
	initial
	begin
		tck_o = 1'b0;
		tap_o = '{tms: 1'b1, tdi: 1'b1};
		last  = 1'b0;
	end

	// ------------------------------------------------------------
	// one test clock period
	// ------------------------------------------------------------
	// tdo is read just before the rise, where it stands since the fall
	// a released line shows the inverse of its last value, not a stale copy
	task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
		tap_o = '{tms: tms, tdi: tdi};
		#24;
		oe_n  = tdo_oe_n_i;
		tdo   = (tdo_oe_n_i === 1'b0) ? tdo_i : ~last;
		last  = tdo;
		tck_o = 1'b1;
		#24;
		tck_o = 1'b0;
	endtask

	task automatic ones(input int n);
		logic t;
		logic o;
		repeat (n) step(1'b1, 1'b1, t, o);
	endtask

	// shift n bits LSB first, leave through Update back to Idle
	task automatic shift(input logic [63:0] din, input int n, output logic [63:0] dout,
		inout logic bad);
		logic t;
		logic o;
		dout = '0;
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], t, o);
			dout[i] = t;
			bad     = bad | (o !== 1'b0);
		end
		step(1'b1, 1'b1, t, o);
		bad = bad | (o !== 1'b1);
		step(1'b0, 1'b1, t, o);
	endtask

	task automatic ir_scan(input logic [2:0] op, output logic [2:0] cap, output logic bad);
		logic [63:0] d;
		logic        t;
		logic        o;
		bad = 1'b0;
		ones(2);
		step(1'b0, 1'b1, t, o);
		step(1'b0, 1'b1, t, o);
		shift({61'h0, op}, 3, d, bad);
		cap = d[2:0];
	endtask

	task automatic dr_scan(input logic [63:0] din, input int n, output logic [63:0] dout,
		output logic bad);
		logic t;
		logic o;
		bad = 1'b0;
		ones(1);
		step(1'b0, 1'b1, t, o);
		step(1'b0, 1'b1, t, o);
		shift(din, n, dout, bad);
	endtask

	// enter Shift-DR, the farthest point from reset, then five high edges
	task automatic tap_reset();
		logic t;
		logic o;
		ones(1);
		step(1'b0, 1'b1, t, o);
		step(1'b0, 1'b1, t, o);
		ones(5);
		step(1'b0, 1'b1, t, o);
	endtask
endmodule

// ===== sbt_tap_tb.sv
// self-checking bench of the boundary-scan port, driven by the controller model
// assumes the 25 MHz memory clock and the 48 ns test clock are unrelated
`timescale 1ns/1ps

module sbt_tap_tb;
	localparam int unsigned BSR_W = 8;

	logic                 clk_i     = 1'b0;
	logic                 sys_rst_i = 1'b1;
	logic                 tck_i;
	sbt_pkg::sbt_tap_in_s tap_i;
	logic [BSR_W-1:0]     ring_i    = 8'h00;
	logic                 tdo_o;
	logic                 tdo_oe_n_o;
	logic                 mem_out_disable_o;
	int                   mismatches  = 0;
	int                   comparisons = 0;
	logic [63:0]          dout;
	logic [2:0]           cap;
	logic                 bad;

	always #20 clk_i = ~clk_i;

	sbt_tap #(.BSR_W(BSR_W)) sbt_tap_inst (
		.clk_i             (clk_i),
		.sys_rst_i         (sys_rst_i),
		.tck_i             (tck_i),
		.tap_i             (tap_i),
		.ring_i            (ring_i),
		.tdo_o             (tdo_o),
		.tdo_oe_n_o        (tdo_oe_n_o),
		.mem_out_disable_o (mem_out_disable_o)
	);

	sbt_jtag_model sbt_jtag_model_inst (
		.tck_o      (tck_i),
		.tap_o      (tap_i),
		.tdo_i      (tdo_o),
		.tdo_oe_n_i (tdo_oe_n_o)
	);

	// ------------------------------------------------------------
	// checking and reporting
	// ------------------------------------------------------------
	task automatic chk_vec(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task final_report();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// load an instruction, then let the output-disable level cross to clk_i
	task automatic load_ir(input logic [2:0] op);
		sbt_jtag_model_inst.ir_scan(op, cap, bad);
		chk_vec({61'h0, cap}, 64'h0000_0000_0000_0001);
		chk_vec({63'h0, bad}, 64'h0000_0000_0000_0000);
		repeat (12) @(posedge clk_i);
		chk_vec({63'h0, mem_out_disable_o}, {63'h0, op == 3'h0 || op == 3'h2});
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		fork
			repeat (20) @(posedge clk_i);
			sbt_jtag_model_inst.ones(4);
		join
		@(posedge clk_i) sys_rst_i <= 1'b0;
		sbt_jtag_model_inst.ones(3);
		chk_vec({63'h0, tdo_oe_n_o}, 64'h0000_0000_0000_0001);
		chk_vec({63'h0, mem_out_disable_o}, 64'h0000_0000_0000_0000);
		// the scan tasks start from Idle, the controller still sits in reset
		sbt_jtag_model_inst.tap_reset();
		$display("test reset done");
	endtask

	// 40 bits: the code leaves LSB first, then tdi shows up from the MSB end
	task automatic t_idcode();
		sbt_jtag_model_inst.dr_scan(64'h0000_0000_0000_00C3, 40, dout, bad);
		chk_vec(dout, {24'h00_0000, 8'hC3, sbt_pkg::ID_VALUE});
		chk_vec({63'h0, bad}, 64'h0000_0000_0000_0000);
		$display("test idcode done");
	endtask

	// reserved codes must behave exactly like the bypass code
	task automatic t_bypass();
		logic [2:0] ops [4];
		ops = '{3'h7, 3'h3, 3'h5, 3'h6};
		foreach (ops[i])
		begin
			load_ir(ops[i]);
			sbt_jtag_model_inst.dr_scan(64'h0000_0000_0000_000B, 4, dout, bad);
			chk_vec(dout, 64'h0000_0000_0000_0006);
		end
		$display("test bypass done");
	endtask

	// twice the chain length shows both the captured ring and the cell count
	task automatic t_ring();
		logic [2:0] ops [3];
		ops = '{3'h0, 3'h4, 3'h2};
		foreach (ops[i])
		begin
			@(posedge clk_i) ring_i <= 8'hA0 | {5'h00, ops[i]};
			repeat (20) @(posedge clk_i);
			load_ir(ops[i]);
			sbt_jtag_model_inst.dr_scan(64'h0000_0000_0000_003C, 16, dout, bad);
			chk_vec(dout, {48'h0, 8'h3C, 8'hA0 | {5'h00, ops[i]}});
		end
		$display("test ring done");
	endtask

	task automatic t_tlr();
		load_ir(3'h0);
		sbt_jtag_model_inst.tap_reset();
		repeat (12) @(posedge clk_i);
		chk_vec({63'h0, mem_out_disable_o}, 64'h0000_0000_0000_0000);
		sbt_jtag_model_inst.dr_scan(64'h0, 32, dout, bad);
		chk_vec(dout, {32'h0000_0000, sbt_pkg::ID_VALUE});
		$display("test mode-select reset done");
	endtask

	// ------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------
	initial
	begin
		t_reset();
		t_idcode();
		t_bypass();
		t_ring();
		t_tlr();
		final_report();
	end

	initial
	begin
		#500_000;
		mismatches++;
		final_report();
	end
endmodule
